// ### hdl/rcr_pkg.sv
// Constants, register map and carrier types of the relay I/O and
// recorder block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package rcr_pkg;

	// Clock and timing.
	localparam int CLK_NS          = 10;
	localparam int CLK_HZ          = 100_000_000;
	localparam int RATED_HZ        = 50;
	localparam int SAMPLES_PER_CYC = 40;
	localparam int REC_CYCLES      = 30;
	localparam int REC_DEPTH       = REC_CYCLES * SAMPLES_PER_CYC;
	localparam int SAMPLE_DIV      = CLK_HZ / (SAMPLES_PER_CYC * RATED_HZ);
	localparam int MS_NS           = 1_000_000;
	localparam int MS_DIV          = MS_NS / CLK_NS;

	// Breaker backup delay in milliseconds.
	localparam int BK_DEFAULT_MS = 110;
	localparam int BK_LOW_MS     = 100;
	localparam int BK_STEP_LO_MS = 20;
	localparam int BK_MID_MS     = 440;
	localparam int BK_STEP_HI_MS = 40;
	localparam int BK_MID_CODE   = 17;

	// Register byte addresses.
	localparam logic [7:0] ADDR_POLARITY   = 8'h00;
	localparam logic [7:0] ADDR_BLOCK      = 8'h04;
	localparam logic [7:0] ADDR_BANK       = 8'h08;
	localparam logic [7:0] ADDR_RESET_CFG  = 8'h0C;
	localparam logic [7:0] ADDR_LATCH      = 8'h10;
	localparam logic [7:0] ADDR_BACKUP     = 8'h14;
	localparam logic [7:0] ADDR_CLEAR      = 8'h18;
	localparam logic [7:0] ADDR_TRIG_MASK  = 8'h1C;
	localparam logic [7:0] ADDR_TRIG_EDGE  = 8'h20;
	localparam logic [7:0] ADDR_POST_LEN   = 8'h24;
	localparam logic [7:0] ADDR_REC_STATE  = 8'h28;
	localparam logic [7:0] ADDR_REC_DATA   = 8'h2C;
	localparam logic [7:0] ADDR_STATUS     = 8'h30;
	localparam logic [7:0] ADDR_SET_MAIN   = 8'h34;
	localparam logic [7:0] ADDR_SET_SECOND = 8'h38;
	localparam logic [7:0] ADDR_ROUTE_BASE = 8'h40;
	localparam logic [7:0] ADDR_ROUTE_LAST = 8'h68;

	// Field positions.
	localparam int BANK_CMD_BIT   = 2;
	localparam int BANK_STAT_BIT  = 8;
	localparam int CLR_IO_BIT     = 0;
	localparam int CLR_ALL_BIT    = 1;
	localparam int LAMP_SW_LSB    = 8;
	localparam int BK_CODE_LSB    = 3;
	localparam int BLOCK_LV_LSB   = 8;
	localparam int CTRL_MASK_LSB  = 4;

	// Reset values.
	localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
	localparam logic [4:0]  RST_BK_CODE   = 5'h00;
	localparam logic [4:0]  RST_POST_LEN  = 5'h0A;
	localparam logic [15:0] RST_SETTING   = 16'h0000;

	// Number of routing sources and relay outputs.
	localparam int N_SRC  = 11;
	localparam int N_OUT  = 8;
	localparam int N_EXT  = 5;
	localparam int N_CTRL = 8;

	typedef enum logic [1:0] {
		REC_ARMED = 2'b00,
		REC_POST  = 2'b01,
		REC_FULL  = 2'b10
	} rcr_rec_state_t;

	typedef struct packed {
		logic hv_start;
		logic hv_operate;
		logic hv_block;
		logic lv_start;
		logic lv_operate;
		logic lv_block;
	} rcr_stage_t;

	typedef struct packed {
		logic [7:0][15:0] analog;
		logic [11:0]      digital;
	} rcr_sample_t;

endpackage : rcr_pkg

// ### hdl/rcr_relay_io.sv
// Relay I/O control, breaker failure backup, setting banks, reset
// paths and integrated disturbance recorder, behind an APB slave.
// Assumes stage, panel and analog inputs come from logic on clk_sys;
// external and sibling block lines are asynchronous pins.
//
// Function
// R1: Five external control lines route or block.
// R2: Mirror sibling blocks; never drive relays.
// R3: Per-input polarity: energized or de-energized active.
// R4: Routing switches link any source to outputs.
// R5: Latched outputs hold until valid reset.
// R6: Lamp_a lamp latches from selected lamp_a outputs.
// R7: Backup lamp_a after delay if fault persists.
// R8: Delay steps 20 ms low, 40 ms high.
// R9: Backup enable and delay from switch bits.
// R10: Two banks, selected by serial, input, panel.
// R11: Input bank select overrides serial and panel.
// R12: Serial reaches both banks; panel active only.
// R13: Three reset levels from buttons, params, inputs.
// R14: One 30-cycle record; no overwrite until emptied.
// R15: Clearing recorded values empties recorder memory.
// R16: Sample rate is 40 times rated frequency.
// R17: Triggers from four internal, eight control signals.
// R18: Start on selected edge of enabled source.
// R19: Masks pick sources; edge bits pick polarity.
// R20: Post-trigger cycles set by post length.
// R21: Flag 0 empty, 1 full; write 0 rearms.
// R22: Show letter d while record stored.
// R23: Record read back sample by sample, in order.
`timescale 1ns/100ps
`default_nettype none

module rcr_relay_io
	import rcr_pkg::*;
#(
	parameter int SAMPLE_DIV_P = rcr_pkg::SAMPLE_DIV,
	parameter int MS_DIV_P     = rcr_pkg::MS_DIV
)
(
	// Clock and reset.
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output var  logic [31:0]          prdata,
	output var  logic                 pready,
	output var  logic                 pslverr,
	// Asynchronous input pins.
	input  wire logic [4:0]           external_control_lines,
	input  wire logic [2:0]           sibling_block_lines,
	// Protection stages and analog front end.
	input  wire rcr_pkg::rcr_stage_t  stage_in,
	input  wire logic [7:0][15:0]     analog_in,
	// Front panel.
	input  wire logic                 panel_reset_btn,
	input  wire logic                 panel_program_btn,
	input  wire logic                 panel_bank_wr,
	input  wire logic                 panel_bank_val,
	input  wire logic                 panel_set_wr,
	input  wire logic [15:0]          panel_set_data,
	input  wire logic                 panel_value_shown,
	// Relays, indicators and stage controls.
	output var  logic [3:0]           start_outputs,
	output var  logic [3:0]           lamp_a_outputs,
	output var  logic                 lamp_a,
	output var  logic [2:0]           intermodule_block_lines,
	output var  logic                 stage_block_hv,
	output var  logic                 stage_block_lv,
	output var  logic                 bank_second,
	output var  logic [15:0]          active_setting,
	output var  logic                 display_d
);
	import rcr_pkg::*;

	logic [4:0]   ext_s1_reg, ext_s2_reg;
	logic [2:0]   sib_s1_reg, sib_s2_reg;
	logic [7:0]   ctrl_act_reg, ctrl_prev_reg;
	logic [3:0]   int_prev_reg;
	logic [7:0]   polarity_reg;
	logic [15:0]  block_reg;
	logic [1:0]   bank_sel_reg;
	logic         bank_cmd_reg;
	logic [5:0]   rst_cfg_reg;
	logic [11:0]  latch_reg;
	logic [7:0]   backup_reg;
	logic [11:0]  trig_mask_reg;
	logic [1:0]   trig_edge_reg;
	logic [4:0]   post_len_reg;
	logic [15:0]  set_main_reg, set_second_reg;
	logic [7:0]   route_reg [N_SRC];
	logic [7:0]   out_reg;
	logic         bk_lamp_a_reg;
	logic [16:0]  ms_div_reg;
	logic [9:0]   ms_cnt_reg;
	logic [16:0]  sdiv_reg;
	logic         stick_reg;
	rcr_rec_state_t rec_state_reg;
	logic [10:0]  wr_ptr_reg, rd_ptr_reg, post_cnt_reg;
	logic [3:0]   word_reg;
	rcr_sample_t  rec_mem [REC_DEPTH];
	logic         pready_reg;

	logic         wr_en, rd_en;
	logic [7:0]   ctrl_next;
	logic         bank_now;
	logic [N_SRC-1:0] src;
	logic [N_OUT-1:0] routed;
	logic [N_OUT-1:0] out_next;
	logic         clr_ind, clr_out, clr_all;
	logic [2:0]   in_lvl1, in_lvl2, in_lvl3;
	logic         bk_cond;
	logic [9:0]   bk_delay_ms;
	logic [4:0]   bk_code;
	logic         trig;
	logic [3:0]   int_cur, int_sel;
	logic [7:0]   ctrl_sel;
	logic [4:0]   plen;
	logic [10:0]  post_samples;
	rcr_sample_t  rd_sample;
	logic [31:0]  rd_word;
	logic [31:0]  rdata_next;
	logic         unmapped;
	logic [3:0]   route_idx;

	assign wr_en = psel & penable & pready_reg & pwrite;
	assign rd_en = psel & penable & pready_reg & ~pwrite;

	// Input pins pass two flip-flops before use.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_s1_reg <= 5'h00;
			ext_s2_reg <= 5'h00;
			sib_s1_reg <= 3'h0;
			sib_s2_reg <= 3'h0;
		end
		else
		begin
			ext_s1_reg <= external_control_lines;
			ext_s2_reg <= ext_s1_reg;
			sib_s1_reg <= sibling_block_lines;
			sib_s2_reg <= sib_s1_reg;
		end
	end

	// R3: polarity per input
	assign ctrl_next = {sib_s2_reg, ext_s2_reg} ^ polarity_reg;
	assign int_cur = {stage_in.lv_block, stage_in.hv_block,
		stage_in.lv_start, stage_in.hv_start};

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_act_reg  <= 8'h00;
			ctrl_prev_reg <= 8'h00;
			int_prev_reg  <= 4'h0;
			intermodule_block_lines <= 3'h0;
			stage_block_hv <= 1'b0;
			stage_block_lv <= 1'b0;
		end
		else
		begin
			ctrl_act_reg  <= ctrl_next;
			ctrl_prev_reg <= ctrl_act_reg;
			int_prev_reg  <= int_cur;
			// R2: mirror sibling block
			intermodule_block_lines <= ctrl_act_reg[7:5];
			// R1: inputs block stages
			stage_block_hv <= |(ctrl_act_reg & block_reg[7:0]);
			stage_block_lv <= |(ctrl_act_reg & block_reg[15:8]);
		end
	end

	// Configuration registers written over APB.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			polarity_reg  <= RST_ZERO[7:0];
			block_reg     <= RST_ZERO[15:0];
			bank_sel_reg  <= RST_ZERO[1:0];
			rst_cfg_reg   <= RST_ZERO[5:0];
			latch_reg     <= RST_ZERO[11:0];
			backup_reg    <= {RST_BK_CODE, 3'h0};
			trig_mask_reg <= RST_ZERO[11:0];
			trig_edge_reg <= RST_ZERO[1:0];
			post_len_reg  <= RST_POST_LEN;
			for (int i = 0; i < N_SRC; i++)
				route_reg[i] <= RST_ZERO[7:0];
		end
		else if (wr_en)
		begin
			unique case (paddr)
				ADDR_POLARITY:  polarity_reg  <= pwdata[7:0];
				ADDR_BLOCK:     block_reg     <= pwdata[15:0];
				ADDR_BANK:      bank_sel_reg  <= pwdata[1:0];
				ADDR_RESET_CFG: rst_cfg_reg   <= pwdata[5:0];
				ADDR_LATCH:     latch_reg     <= pwdata[11:0];
				// R9: enable and delay code
				ADDR_BACKUP:    backup_reg    <= pwdata[7:0];
				ADDR_TRIG_MASK: trig_mask_reg <= pwdata[11:0];
				ADDR_TRIG_EDGE: trig_edge_reg <= pwdata[1:0];
				ADDR_POST_LEN:  post_len_reg  <= pwdata[4:0];
				default:
				begin
					// Only aligned routing offsets may reach the switch bank.
					if (paddr >= ADDR_ROUTE_BASE && paddr <= ADDR_ROUTE_LAST
						&& paddr[1:0] == 2'h0)
						route_reg[route_idx] <= pwdata[7:0];
				end
			endcase
		end
	end

	// R10: bank selection sources
	assign bank_now = (bank_sel_reg == 2'h0) ? bank_cmd_reg
		: ctrl_act_reg[bank_sel_reg - 2'h1];

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bank_cmd_reg   <= 1'b0;
			bank_second    <= 1'b0;
			set_main_reg   <= RST_SETTING;
			set_second_reg <= RST_SETTING;
			active_setting <= RST_SETTING;
		end
		else
		begin
			// R11: input select overrides
			if (bank_sel_reg == 2'h0)
			begin
				if (wr_en && paddr == ADDR_BANK)
					bank_cmd_reg <= pwdata[BANK_CMD_BIT];
				else if (panel_bank_wr)
					bank_cmd_reg <= panel_bank_val;
			end
			bank_second <= bank_now;
			// R12: serial both, panel active
			if (wr_en && paddr == ADDR_SET_MAIN)
				set_main_reg <= pwdata[15:0];
			else if (panel_set_wr && !bank_now)
				set_main_reg <= panel_set_data;
			if (wr_en && paddr == ADDR_SET_SECOND)
				set_second_reg <= pwdata[15:0];
			else if (panel_set_wr && bank_now)
				set_second_reg <= panel_set_data;
			active_setting <= bank_now ? set_second_reg : set_main_reg;
		end
	end

	// R13: three reset levels
	generate
		for (genvar k = 0; k < 3; k++)
		begin : g_rst_in
			logic rise;
			assign rise = ctrl_act_reg[k] & ~ctrl_prev_reg[k];
			assign in_lvl1[k] = rise && rst_cfg_reg[2*k +: 2] == 2'h1;
			assign in_lvl2[k] = rise && rst_cfg_reg[2*k +: 2] == 2'h2;
			assign in_lvl3[k] = rise && rst_cfg_reg[2*k +: 2] == 2'h3;
		end
	endgenerate

	assign clr_all = (panel_reset_btn & panel_program_btn) | (|in_lvl3)
		| (wr_en && paddr == ADDR_CLEAR && pwdata[CLR_ALL_BIT]);
	assign clr_out = clr_all | panel_program_btn | (|in_lvl2)
		| (wr_en && paddr == ADDR_CLEAR && pwdata[CLR_IO_BIT]);
	assign clr_ind = clr_out | panel_reset_btn | (|in_lvl1);

	// R2: sibling lines are no source
	assign src = {ctrl_act_reg[4:0], stage_in.lv_block,
		stage_in.lv_operate & ~stage_block_lv, stage_in.lv_start,
		stage_in.hv_block, stage_in.hv_operate & ~stage_block_hv,
		stage_in.hv_start};

	// R4: routing switch matrix
	generate
		for (genvar j = 0; j < N_OUT; j++)
		begin : g_route
			logic [N_SRC-1:0] col;
			for (genvar i = 0; i < N_SRC; i++)
			begin : g_col
				assign col[i] = route_reg[i][j];
			end
			assign routed[j] = |(src & col);
		end
	endgenerate

	// R5: latch held until output reset
	assign out_next = {routed[7:5], routed[4] | bk_lamp_a_reg, routed[3:0]}
		| (out_reg & latch_reg[7:0] & {N_OUT{~clr_out}});

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_reg <= 8'h00;
			lamp_a  <= 1'b0;
		end
		else
		begin
			out_reg <= out_next;
			// R6: lamp_a lamp latches
			lamp_a <= (|(out_next[7:4] & latch_reg[LAMP_SW_LSB +: 4]))
				| (lamp_a & ~clr_ind);
		end
	end

	assign start_outputs = out_reg[3:0];
	assign lamp_a_outputs  = out_reg[7:4];

	// R8: 20 ms then 40 ms steps
	assign bk_code = backup_reg[BK_CODE_LSB +: 5];
	always_comb
	begin
		if (bk_code == 5'h00)
			bk_delay_ms = 10'(BK_DEFAULT_MS);
		else if (bk_code <= 5'(BK_MID_CODE))
			bk_delay_ms = 10'(BK_LOW_MS) + 10'(bk_code) * 10'(BK_STEP_LO_MS);
		else
			bk_delay_ms = 10'(BK_MID_MS)
				+ 10'(bk_code - 5'(BK_MID_CODE)) * 10'(BK_STEP_HI_MS);
	end

	assign bk_cond = |(routed[7:5] & backup_reg[2:0]);

	// R7: backup timer restarts on loss
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ms_div_reg  <= 17'h00000;
			ms_cnt_reg  <= 10'h000;
			bk_lamp_a_reg <= 1'b0;
		end
		else if (!bk_cond)
		begin
			ms_div_reg  <= 17'h00000;
			ms_cnt_reg  <= 10'h000;
			bk_lamp_a_reg <= 1'b0;
		end
		else
		begin
			if (ms_div_reg == 17'(MS_DIV_P - 1))
			begin
				ms_div_reg <= 17'h00000;
				if (ms_cnt_reg < bk_delay_ms)
					ms_cnt_reg <= ms_cnt_reg + 10'h001;
			end
			else
				ms_div_reg <= ms_div_reg + 17'h00001;
			bk_lamp_a_reg <= ms_cnt_reg >= bk_delay_ms;
		end
	end

	// R16: sample enable divider
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sdiv_reg  <= 17'h00000;
			stick_reg <= 1'b0;
		end
		else
		begin
			stick_reg <= sdiv_reg == 17'(SAMPLE_DIV_P - 1);
			if (sdiv_reg == 17'(SAMPLE_DIV_P - 1))
				sdiv_reg <= 17'h00000;
			else
				sdiv_reg <= sdiv_reg + 17'h00001;
		end
	end

	// R18: edge select per group
	assign int_sel = trig_edge_reg[0] ? (int_prev_reg & ~int_cur)
		: (int_cur & ~int_prev_reg);
	assign ctrl_sel = trig_edge_reg[1] ? (ctrl_prev_reg & ~ctrl_act_reg)
		: (ctrl_act_reg & ~ctrl_prev_reg);
	// R17: twelve trigger sources
	// R19: masks enable sources
	assign trig = |(int_sel & trig_mask_reg[3:0])
		| |(ctrl_sel & trig_mask_reg[CTRL_MASK_LSB +: N_CTRL]);

	// R20: post-trigger length in samples
	assign plen = (post_len_reg > 5'(REC_CYCLES)) ? 5'(REC_CYCLES)
		: post_len_reg;
	assign post_samples = 11'(plen) * 11'(SAMPLES_PER_CYC);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rec_state_reg <= REC_ARMED;
			wr_ptr_reg    <= 11'h000;
			rd_ptr_reg    <= 11'h000;
			post_cnt_reg  <= 11'h000;
			word_reg      <= 4'h0;
		end
		// R15: clear all empties memory
		else if (clr_all)
		begin
			rec_state_reg <= REC_ARMED;
			wr_ptr_reg    <= 11'h000;
		end
		else
		begin
			unique case (rec_state_reg)
				REC_ARMED, REC_POST:
				begin
					if (stick_reg)
						wr_ptr_reg <= (wr_ptr_reg == 11'(REC_DEPTH - 1))
							? 11'h000 : wr_ptr_reg + 11'h001;
					if (rec_state_reg == REC_ARMED && trig)
					begin
						rec_state_reg <= (post_samples == 11'h000)
							? REC_FULL : REC_POST;
						post_cnt_reg  <= post_samples;
						rd_ptr_reg    <= wr_ptr_reg;
						word_reg      <= 4'h0;
					end
					else if (rec_state_reg == REC_POST && stick_reg)
					begin
						post_cnt_reg <= post_cnt_reg - 11'h001;
						if (post_cnt_reg == 11'h001)
						begin
							rec_state_reg <= REC_FULL;
							rd_ptr_reg    <= (wr_ptr_reg == 11'(REC_DEPTH - 1))
								? 11'h000 : wr_ptr_reg + 11'h001;
						end
					end
				end
				// R14: hold record until emptied
				REC_FULL:
				begin
					// R21: host writes 0 to empty
					if (wr_en && paddr == ADDR_REC_STATE && !pwdata[0])
					begin
						rec_state_reg <= REC_ARMED;
						wr_ptr_reg    <= 11'h000;
					end
					// R23: advance in capture order
					else if (rd_en && paddr == ADDR_REC_DATA)
					begin
						if (word_reg == 4'h8)
						begin
							word_reg   <= 4'h0;
							rd_ptr_reg <= (rd_ptr_reg == 11'(REC_DEPTH - 1))
								? 11'h000 : rd_ptr_reg + 11'h001;
						end
						else
							word_reg <= word_reg + 4'h1;
					end
				end
				default: rec_state_reg <= REC_ARMED;
			endcase
		end
	end

	// R14: eight analog, twelve digital
	always_ff @(posedge clk_sys)
	begin
		if (stick_reg && rec_state_reg != REC_FULL)
			rec_mem[wr_ptr_reg] <= '{analog: analog_in,
				digital: {ctrl_act_reg, int_cur}};
	end

	assign rd_sample = rec_mem[rd_ptr_reg];
	assign rd_word = (word_reg == 4'h8) ? {20'h00000, rd_sample.digital}
		: {16'h0000, rd_sample.analog[word_reg[2:0]]};

	// R22: letter d while stored
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			display_d <= 1'b0;
		else
			display_d <= rec_state_reg == REC_FULL && !panel_value_shown;
	end

	assign route_idx = 4'((paddr - ADDR_ROUTE_BASE) >> 2);

	always_comb
	begin
		rdata_next = 32'h0000_0000;
		unmapped   = 1'b0;
		unique case (paddr)
			ADDR_POLARITY:   rdata_next[7:0]  = polarity_reg;
			ADDR_BLOCK:      rdata_next[15:0] = block_reg;
			ADDR_BANK:
			begin
				rdata_next[1:0]           = bank_sel_reg;
				rdata_next[BANK_CMD_BIT]  = bank_cmd_reg;
				rdata_next[BANK_STAT_BIT] = bank_second;
			end
			ADDR_RESET_CFG:  rdata_next[5:0]  = rst_cfg_reg;
			ADDR_LATCH:      rdata_next[11:0] = latch_reg;
			ADDR_BACKUP:     rdata_next[7:0]  = backup_reg;
			ADDR_CLEAR:      rdata_next       = 32'h0000_0000;
			ADDR_TRIG_MASK:  rdata_next[11:0] = trig_mask_reg;
			ADDR_TRIG_EDGE:  rdata_next[1:0]  = trig_edge_reg;
			ADDR_POST_LEN:   rdata_next[4:0]  = post_len_reg;
			// R21: flag 1 only when full
			ADDR_REC_STATE:  rdata_next[0]    = rec_state_reg == REC_FULL;
			ADDR_REC_DATA:
				if (rec_state_reg == REC_FULL)
					rdata_next = rd_word;
			ADDR_STATUS:
				rdata_next[11:0] = {bk_lamp_a_reg, display_d, bank_second,
					lamp_a, out_reg};
			ADDR_SET_MAIN:   rdata_next[15:0] = set_main_reg;
			ADDR_SET_SECOND: rdata_next[15:0] = set_second_reg;
			default:
			begin
				if (paddr >= ADDR_ROUTE_BASE && paddr <= ADDR_ROUTE_LAST
					&& paddr[1:0] == 2'h0)
					rdata_next[7:0] = route_reg[route_idx];
				else
					unmapped = 1'b1;
			end
		endcase
	end

	// Every access takes exactly one wait-free access cycle.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_reg <= 1'b0;
			prdata     <= 32'h0000_0000;
			pslverr    <= 1'b0;
		end
		else
		begin
			pready_reg <= psel & ~penable;
			if (psel && !penable)
			begin
				prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
				pslverr <= unmapped;
			end
		end
	end

	assign pready = pready_reg;

endmodule : rcr_relay_io

`default_nettype wire

// ### tb/rcr_relay_io_chk.sv
// Port assertions for the relay I/O and recorder block.
// Bound to every rcr_relay_io instance; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rcr_relay_io_chk
(
	// Watched ports.
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [3:0]  start_outputs,
	input wire logic [3:0]  lamp_a_outputs,
	input wire logic        lamp_a,
	input wire logic        panel_value_shown,
	input wire logic        display_d
);
	logic setup;
	logic bad;
	assign setup = psel && !penable;
	assign bad = paddr[1:0] != 2'h0 || paddr > 8'h68
		|| (paddr > 8'h38 && paddr < 8'h40);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	chk_ready_after_setup: assert property (setup |=> pready)
		else $error("no ready after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_ready_cause: assert property (pready |-> $past(setup))
		else $error("ready without setup");
	chk_slverr_map: assert property (setup |=> pslverr == $past(bad))
		else $error("error flag disagrees with map");
	chk_write_rdata: assert property (setup && pwrite |=> prdata == 32'h0)
		else $error("read data not zero on write");
	chk_reset_quiet: assert property (!$past(rst_n) |->
		start_outputs == 4'h0 && lamp_a_outputs == 4'h0 && !lamp_a)
		else $error("relays active after reset");
	chk_lamp_cause: assert property ($rose(lamp_a) |->
		lamp_a_outputs != 4'h0 || $past(lamp_a_outputs) != 4'h0)
		else $error("lamp lit without lamp_a");
	chk_disp_hidden: assert property (display_d |-> !$past(panel_value_shown))
		else $error("letter shown over a value");
endmodule : rcr_relay_io_chk
bind rcr_relay_io rcr_relay_io_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.start_outputs(start_outputs), .lamp_a_outputs(lamp_a_outputs),
	.lamp_a(lamp_a), .panel_value_shown(panel_value_shown),
	.display_d(display_d));
`default_nettype wire

// ### tb/rcr_pin_model.sv
// Far-side pin model: external control and sibling block lines.
// Assumes the bench mirrors the polarity register into pol.
`timescale 1ns/100ps
`default_nettype none
module rcr_pin_model
(
	// Wanted active states and polarity.
	input  wire logic [7:0] act,
	input  wire logic [7:0] pol,
	// Pin levels.
	output logic      [4:0] ext_pins,
	output logic      [2:0] sib_pins
);
	assign ext_pins = act[4:0] ^ pol[4:0];
	assign sib_pins = act[7:5] ^ pol[7:5];
endmodule : rcr_pin_model
`default_nettype wire

// ### tb/rcr_relay_io_tb.sv
// Self-checking bench for the relay I/O and recorder block.
// Uses shortened sample and millisecond dividers.
`timescale 1ns/100ps
`default_nettype none
module rcr_relay_io_tb;
	import rcr_pkg::*;
	localparam int MSD = 4;
	logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0, act = 0, pol = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic pready, pslverr, lamp, bhv, blv, bank, dd;
	logic pr = 0, pp = 0, pbw = 0, pbv = 0, psw = 0, pvs = 0;
	logic [15:0] psd = 0, aset;
	logic [3:0] so, to;
	logic [2:0] iml, sib;
	logic [4:0] ext;
	rcr_stage_t stg = '0;
	logic [7:0][15:0] ana;
	int fails = 0, compares = 0, cyc = 0;
	rcr_pin_model i_pins (.act(act), .pol(pol), .ext_pins(ext),
		.sib_pins(sib));
	rcr_relay_io #(.SAMPLE_DIV_P(8), .MS_DIV_P(MSD)) i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_control_lines(ext),
		.sibling_block_lines(sib), .stage_in(stg), .analog_in(ana),
		.panel_reset_btn(pr), .panel_program_btn(pp), .panel_bank_wr(pbw),
		.panel_bank_val(pbv), .panel_set_wr(psw), .panel_set_data(psd),
		.panel_value_shown(pvs), .start_outputs(so), .lamp_a_outputs(to),
		.lamp_a(lamp), .intermodule_block_lines(iml),
		.stage_block_hv(bhv), .stage_block_lv(blv), .bank_second(bank),
		.active_setting(aset), .display_d(dd));
	always #5 clk_sys = ~clk_sys;
	task automatic test_done();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk
	task automatic t_regs();
		rchk(ADDR_POST_LEN, 32'h0000_000A);
		rchk(ADDR_BACKUP, 32'h0);
		rchk(8'h3C, 32'h0);
		chk(err, 1'b1);
	endtask : t_regs
	task automatic t_latch();
		apb(1'b1, ADDR_ROUTE_BASE, 32'h10);
		apb(1'b1, ADDR_LATCH, 32'h110);
		stg.hv_start <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(to, 4'h1);
		stg.hv_start <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({to, lamp}, 5'h03);
		pr <= 1'b1;
		@(posedge clk_sys);
		pr <= 1'b0;
		repeat (3) @(posedge clk_sys);
		// The latched lamp_a survives the reset button and keeps the lamp lit.
		chk({to, lamp}, 5'h03);
		pp <= 1'b1;
		@(posedge clk_sys);
		pp <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({to, lamp}, 5'h00);
		apb(1'b1, ADDR_LATCH, 32'h100);
		stg.hv_start <= 1'b1;
		@(posedge clk_sys);
		stg.hv_start <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({to, lamp}, 5'h01);
		apb(1'b1, ADDR_RESET_CFG, 32'h1);
		act <= 8'h01;
		repeat (6) @(posedge clk_sys);
		chk({to, lamp}, 5'h00);
		act <= 8'h00;
		apb(1'b1, ADDR_RESET_CFG, 32'h0);
		apb(1'b1, ADDR_LATCH, 32'h0);
		apb(1'b1, ADDR_ROUTE_BASE, 32'h0);
	endtask : t_latch
	task automatic t_pol();
		pol <= 8'hA0;
		apb(1'b1, ADDR_POLARITY, 32'hA0);
		repeat (6) @(posedge clk_sys);
		chk(iml, 3'h0);
		act <= 8'h21;
		repeat (6) @(posedge clk_sys);
		chk(iml, 3'h1);
		apb(1'b1, ADDR_BLOCK, 32'h2001);
		repeat (2) @(posedge clk_sys);
		chk({bhv, blv}, 2'h3);
		apb(1'b1, ADDR_BLOCK, 32'h0);
		act <= 8'h00;
		pol <= 8'h00;
		apb(1'b1, ADDR_POLARITY, 32'h0);
	endtask : t_pol
	task automatic t_bank();
		apb(1'b1, ADDR_BANK, 32'h4);
		apb(1'b1, ADDR_SET_SECOND, 32'hAB);
		repeat (2) @(posedge clk_sys);
		chk({bank, aset}, 17'h100AB);
		psd <= 16'h0055;
		psw <= 1'b1;
		@(posedge clk_sys);
		psw <= 1'b0;
		rchk(ADDR_SET_SECOND, 32'h55);
		rchk(ADDR_SET_MAIN, 32'h0);
		apb(1'b1, ADDR_BANK, 32'h1);
		pbv <= 1'b1;
		pbw <= 1'b1;
		@(posedge clk_sys);
		pbw <= 1'b0;
		apb(1'b1, ADDR_BANK, 32'h5);
		repeat (2) @(posedge clk_sys);
		chk(bank, 1'b0);
		rchk(ADDR_BANK, 32'h1);
		act <= 8'h01;
		repeat (6) @(posedge clk_sys);
		chk(bank, 1'b1);
		act <= 8'h00;
		apb(1'b1, ADDR_BANK, 32'h0);
	endtask : t_bank
	task automatic t_bk(input logic [4:0] code, input int ms);
		apb(1'b1, ADDR_ROUTE_BASE + 8'h04, 32'h20);
		apb(1'b1, ADDR_BACKUP, {24'h0, code, 3'b001});
		stg.hv_operate <= 1'b1;
		repeat (ms * MSD - 8) @(posedge clk_sys);
		chk(to, 4'h2);
		repeat (16) @(posedge clk_sys);
		chk(to, 4'h3);
		stg.hv_operate <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(to, 4'h0);
	endtask : t_bk
	task automatic t_rec();
		apb(1'b1, ADDR_POST_LEN, 32'h0);
		apb(1'b1, ADDR_TRIG_MASK, 32'h1);
		apb(1'b1, ADDR_TRIG_EDGE, 32'h1);
		repeat (9700) @(posedge clk_sys);
		stg.hv_start <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rchk(ADDR_REC_STATE, 32'h0);
		stg.hv_start <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rchk(ADDR_REC_STATE, 32'h1);
		chk(dd, 1'b1);
		pvs <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(dd, 1'b0);
		pvs <= 1'b0;
		for (int k = 0; k < 8; k++)
			rchk(ADDR_REC_DATA, 32'h1000 + k);
		rchk(ADDR_REC_DATA, 32'h0);
		apb(1'b1, ADDR_REC_STATE, 32'h0);
		rchk(ADDR_REC_STATE, 32'h0);
		apb(1'b1, ADDR_POST_LEN, 32'h1);
		stg.hv_start <= 1'b1;
		@(posedge clk_sys);
		stg.hv_start <= 1'b0;
		repeat (290) @(posedge clk_sys);
		rchk(ADDR_REC_STATE, 32'h0);
		repeat (40) @(posedge clk_sys);
		rchk(ADDR_REC_STATE, 32'h1);
		apb(1'b1, ADDR_CLEAR, 32'h2);
		rchk(ADDR_REC_STATE, 32'h0);
	endtask : t_rec
	initial
	begin
		for (int k = 0; k < 8; k++)
			ana[k] = 16'h1000 + 16'(k);
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		t_latch();
		t_pol();
		t_bank();
		t_bk(5'd0, 110);
		t_bk(5'd1, 120);
		t_bk(5'd18, 480);
		t_rec();
		test_done();
	end
endmodule : rcr_relay_io_tb
`default_nettype wire
